// ### rtl/frame_switch_core.sv
// Purpose: Store-and-forward switching core with address learning
// Assumes: One ingress stream tagged with its port, one egress stream
// Notes: Sweeps of the address table hold off reception while running
`timescale 1ns/10ps
// Notes on behaviour
// - Store whole frame, validate, then forward
// - Drop frames over 1536 bytes or bad CRC
// - Drop fragments under 64 bytes
// - Table holds 16386 entries with port
// - Learn source address and ingress port
// - Known destination goes to its port only
// - Flood unknown, multicast, broadcast destinations
// - Age out entries, 40 s default, 10-825
// - Restart invalidates every table entry
// - Link loss removes that port's entries
// - Clear command empties the whole table
// - Eight classes from tag priority 0-7
// - Bridge protocol frames get top class
// - Tagged frames queued by tag priority
// - Untagged other frames get lowest class
// - Classes fold into four processing queues
// - Table empty after reset to defaults
module frame_switch_core #(
    parameter int NUM_PORTS = 4,
    parameter int DEPTH = fsw_pkg::TABLE_DEPTH,
    parameter int SEC_CYCLES = fsw_pkg::SEC_CYCLES
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic rx_valid,
    output logic rx_ready,
    input wire logic [7:0] rx_data,
    input wire logic rx_last,
    input wire logic rx_crc_err,
    input wire logic [$clog2(NUM_PORTS)-1:0] rx_port,
    input wire logic [NUM_PORTS-1:0] link_up,
    input wire logic clear_table,
    input wire logic [9:0] age_time_s,
    output logic tx_valid,
    input wire logic tx_ready,
    output logic [7:0] tx_data,
    output logic tx_last,
    output logic [NUM_PORTS-1:0] tx_port_mask,
    output logic [2:0] tx_class,
    output logic [1:0] tx_queue
);
    localparam int PW = $clog2(NUM_PORTS);
    localparam int IW = $clog2(DEPTH);
    localparam logic [IW-1:0] LAST_IDX = IW'(DEPTH - 1);
    localparam logic [31:0] SEC_LAST = 32'(SEC_CYCLES - 1);

    // Whole controller state
    typedef struct packed {
        fsw_pkg::state_t st;
        logic [10:0] len;       // Bytes received or frame length
        logic [10:0] rd_ptr;    // Next buffer byte to send
        logic [47:0] da;
        logic [47:0] sa;
        logic [15:0] etype;
        logic [2:0] pcp;
        logic [PW-1:0] src_port;
        logic [31:0] sec_div;   // One-second divider
        logic [15:0] now;       // Seconds, wraps freely
        logic [IW-1:0] sw_idx;
        logic sw_all;
        logic [NUM_PORTS-1:0] sw_down;
        logic clear_pend;
        logic [NUM_PORTS-1:0] down_pend;
        logic [NUM_PORTS-1:0] link_q;
        logic [7:0] tx_data;
        logic [NUM_PORTS-1:0] mask;
        logic [2:0] cls;
    } sw_state_t;

    sw_state_t s_reg, s_next;
    // Frame buffer and address table
    logic [7:0] frame_buf [0:2047];
    logic [47:0] tbl_mac [0:DEPTH-1];
    logic [PW-1:0] tbl_port [0:DEPTH-1];
    logic [15:0] tbl_stamp [0:DEPTH-1];
    logic tbl_valid [0:DEPTH-1];

    // Table write port
    logic tw_en, tw_valid;
    logic [IW-1:0] tw_idx;
    logic buf_we;
    logic [9:0] age_cfg;
    logic [IW-1:0] da_idx, sa_idx;
    logic sec_tick, frame_bad;
    logic [10:0] len_fin;
    // Fold a MAC address onto a table slot
    function automatic logic [IW-1:0] slot(input logic [47:0] mac);
        logic [IW-1:0] h;
        h = '0;
        for (int i = 0; i < 48; i++) begin
            h[i % IW] = h[i % IW] ^ mac[i];
        end
        return IW'(32'(h) % DEPTH);
    endfunction

    // Entry older than the configured aging time
    function automatic logic aged(input logic [15:0] stamp,
                                  input logic [15:0] now,
                                  input logic [9:0] limit);
        return (now - stamp) > {6'h00, limit};
    endfunction

    // Aging time kept inside its legal range
    always_comb begin
        if (age_time_s < fsw_pkg::AGE_MIN_S) begin
            age_cfg = fsw_pkg::AGE_MIN_S;
        end else if (age_time_s > fsw_pkg::AGE_MAX_S) begin
            age_cfg = fsw_pkg::AGE_MAX_S;
        end else begin
            age_cfg = age_time_s;
        end
    end

    assign da_idx = slot(s_reg.da);
    assign sa_idx = slot(s_reg.sa);
    assign sec_tick = s_reg.sec_div == SEC_LAST;
    assign len_fin = (s_reg.len == fsw_pkg::LEN_SAT) ? s_reg.len
                                                     : s_reg.len + 11'h001;
    // Size and check sequence test on the last byte
    assign frame_bad = rx_crc_err || len_fin > fsw_pkg::MAX_FRAME ||
                       len_fin < fsw_pkg::MIN_FRAME;
    assign rx_ready = s_reg.st == fsw_pkg::ST_RX;
    assign buf_we = rx_valid && rx_ready && s_reg.len < fsw_pkg::MAX_FRAME;

    // Next-state logic
    always_comb begin
        logic hit, mcast, bpdu, sa_ok;
        logic [NUM_PORTS-1:0] ev_down;
        ev_down = s_reg.link_q & ~link_up;
        hit = 1'b0;
        mcast = 1'b0;
        bpdu = 1'b0;
        sa_ok = 1'b0;
        s_next = s_reg;
        tw_en = 1'b0;
        tw_valid = 1'b0;
        tw_idx = s_reg.sw_idx;
        // Link and clear events; a new event beats a consumed one
        s_next.link_q = link_up;
        s_next.down_pend = s_reg.down_pend | ev_down;
        s_next.clear_pend = s_reg.clear_pend | clear_table;
        // Seconds time base for aging
        if (sec_tick) begin
            s_next.sec_div = '0;
            s_next.now = s_reg.now + 16'h0001;
        end else begin
            s_next.sec_div = s_reg.sec_div + 32'h0000_0001;
        end
        unique case (s_reg.st)
            fsw_pkg::ST_RX: begin
                if (rx_valid) begin
                    // Capture header fields as they pass
                    if (s_reg.len < fsw_pkg::SA_POS) begin
                        s_next.da = {s_reg.da[39:0], rx_data};
                    end else if (s_reg.len < fsw_pkg::TYPE_POS) begin
                        s_next.sa = {s_reg.sa[39:0], rx_data};
                    end else if (s_reg.len < fsw_pkg::TAG_POS) begin
                        s_next.etype = {s_reg.etype[7:0], rx_data};
                    end else if (s_reg.len == fsw_pkg::TAG_POS) begin
                        s_next.pcp = rx_data[7:5];
                    end
                    s_next.src_port = rx_port;
                    s_next.len = len_fin;
                    if (rx_last) begin
                        // Forward only after the whole frame
                        if (frame_bad) begin
                            s_next.len = '0;
                        end else begin
                            s_next.st = fsw_pkg::ST_LOOK;
                        end
                    end
                end else if (s_reg.len == '0 && (sec_tick ||
                             s_reg.clear_pend || |s_reg.down_pend)) begin
                    // Start a sweep only between frames
                    s_next.st = fsw_pkg::ST_SWEEP;
                    s_next.sw_idx = '0;
                    s_next.sw_all = s_reg.clear_pend;
                    s_next.sw_down = s_reg.down_pend;
                    s_next.clear_pend = clear_table;
                    s_next.down_pend = ev_down;
                end
            end
            fsw_pkg::ST_LOOK: begin
                mcast = s_reg.da[40];
                bpdu = s_reg.da == fsw_pkg::BPDU_DA;
                hit = !mcast && tbl_valid[da_idx] &&
                      tbl_mac[da_idx] == s_reg.da &&
                      !aged(tbl_stamp[da_idx], s_reg.now, age_cfg);
                // Unicast to the learned port, else flood
                if (hit) begin
                    s_next.mask = NUM_PORTS'(1) << tbl_port[da_idx];
                    if (tbl_port[da_idx] == s_reg.src_port) begin
                        s_next.mask = '0;
                    end
                end else begin
                    s_next.mask = ~(NUM_PORTS'(1) << s_reg.src_port);
                end
                s_next.mask = s_next.mask & link_up;
                // Class from tag, control frames on top
                if (bpdu) begin
                    s_next.cls = fsw_pkg::CLASS_HIGH;
                end else if (s_reg.etype == fsw_pkg::TPID) begin
                    s_next.cls = s_reg.pcp;
                end else begin
                    s_next.cls = fsw_pkg::CLASS_LOW;
                end
                // Learn into a free, own or stale slot only
                sa_ok = !tbl_valid[sa_idx] || tbl_mac[sa_idx] == s_reg.sa ||
                        aged(tbl_stamp[sa_idx], s_reg.now, age_cfg);
                tw_en = sa_ok && !s_reg.sa[40];
                tw_valid = 1'b1;
                tw_idx = sa_idx;
                s_next.tx_data = frame_buf[0];
                s_next.rd_ptr = 11'h001;
                if (s_next.mask == '0) begin
                    s_next.st = fsw_pkg::ST_RX;
                    s_next.len = '0;
                end else begin
                    s_next.st = fsw_pkg::ST_TX;
                end
            end
            fsw_pkg::ST_TX: begin
                if (tx_ready) begin
                    if (s_reg.rd_ptr == s_reg.len) begin
                        s_next.st = fsw_pkg::ST_RX;
                        s_next.len = '0;
                    end else begin
                        s_next.tx_data = frame_buf[s_reg.rd_ptr];
                        s_next.rd_ptr = s_reg.rd_ptr + 11'h001;
                    end
                end
            end
            fsw_pkg::ST_SWEEP: begin
                // Remove cleared, link-lost and aged entries
                tw_en = s_reg.sw_all || (tbl_valid[s_reg.sw_idx] &&
                        (s_reg.sw_down[tbl_port[s_reg.sw_idx]] ||
                         aged(tbl_stamp[s_reg.sw_idx], s_reg.now, age_cfg)));
                if (s_reg.sw_idx == LAST_IDX) begin
                    s_next.st = fsw_pkg::ST_RX;
                    s_next.sw_all = 1'b0;
                    s_next.sw_down = '0;
                end else begin
                    s_next.sw_idx = s_reg.sw_idx + IW'(1);
                end
            end
        endcase
    end

    // State register; reset opens with a full-table sweep
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            s_reg <= '0;
            s_reg.st <= fsw_pkg::ST_SWEEP;
            s_reg.sw_all <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    // Frame storage and table writes, no reset on memories
    always_ff @(posedge core_clk) begin
        if (buf_we) begin
            frame_buf[s_reg.len] <= rx_data;
        end
        if (tw_en) begin
            tbl_valid[tw_idx] <= tw_valid;
            tbl_mac[tw_idx] <= s_reg.sa;
            tbl_port[tw_idx] <= s_reg.src_port;
            tbl_stamp[tw_idx] <= s_reg.now;
        end
    end

    // Egress view; queue is the upper two class bits
    assign tx_valid = s_reg.st == fsw_pkg::ST_TX;
    assign tx_data = s_reg.tx_data;
    assign tx_last = tx_valid && s_reg.rd_ptr == s_reg.len;
    assign tx_port_mask = s_reg.mask;
    assign tx_class = s_reg.cls;
    assign tx_queue = s_reg.cls[2:1];

    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    logic acc_last;
    assign acc_last = rx_valid && rx_ready && rx_last;

    a_long_drop: assert property (
        acc_last && len_fin > fsw_pkg::MAX_FRAME
        |=> s_reg.st == fsw_pkg::ST_RX && s_reg.len == '0)
        else $error("oversize frame not dropped");
    a_short_drop: assert property (
        acc_last && len_fin < fsw_pkg::MIN_FRAME
        |=> s_reg.st == fsw_pkg::ST_RX ##1 !tx_valid)
        else $error("fragment not dropped");
    a_good_store: assert property (
        acc_last && !frame_bad |=> s_reg.st == fsw_pkg::ST_LOOK)
        else $error("valid frame not forwarded");
    a_no_cut_through: assert property (
        rx_valid && rx_ready |-> !tx_valid)
        else $error("sending while receiving");
    a_class_high: assert property (
        s_reg.st == fsw_pkg::ST_LOOK && s_reg.da == fsw_pkg::BPDU_DA
        |=> s_reg.cls == 3'h7)
        else $error("control frame not top class");
    a_class_tag: assert property (
        s_reg.st == fsw_pkg::ST_LOOK && s_reg.etype == fsw_pkg::TPID &&
        s_reg.da != fsw_pkg::BPDU_DA |=> s_reg.cls == $past(s_reg.pcp))
        else $error("tag priority not used");
    a_class_low: assert property (
        s_reg.st == fsw_pkg::ST_LOOK && s_reg.etype != fsw_pkg::TPID &&
        s_reg.da != fsw_pkg::BPDU_DA |=> s_reg.cls == 3'h0)
        else $error("untagged frame not low class");
    a_queue_map: assert property (
        tx_valid |-> tx_queue == tx_class[2:1] && tx_port_mask != '0)
        else $error("queue mapping wrong");
    a_link_flush: assert property (
        s_reg.st == fsw_pkg::ST_RX && |(s_reg.link_q & ~link_up)
        |=> |s_reg.down_pend || s_reg.st == fsw_pkg::ST_SWEEP)
        else $error("link loss not recorded");
    a_sweep_block: assert property (
        s_reg.st == fsw_pkg::ST_SWEEP |-> !rx_ready && !tx_valid)
        else $error("traffic during sweep");
    a_no_src_echo: assert property (
        s_reg.st == fsw_pkg::ST_LOOK
        |=> !s_reg.mask[$past(s_reg.src_port)] || s_reg.st != fsw_pkg::ST_TX)
        else $error("frame sent back to source");

    c_forward: cover property (acc_last && !frame_bad ##[1:3] tx_valid);
    c_drop: cover property (acc_last && frame_bad);
    c_bpdu: cover property (tx_valid && tx_class == 3'h7);
    c_sweep: cover property (s_reg.st == fsw_pkg::ST_SWEEP && !s_reg.sw_all);
endmodule

// ### rtl/fsw_pkg.sv
// Purpose: Shared constants of the learning frame switch core
// Assumes: 100 MHz core clock, byte-wide frame streams
// Notes: Frame lengths count every byte including the check sequence
package fsw_pkg;
    // Clock and time base
    localparam int CLK_PERIOD_NS = 10;
    localparam int SEC_NS = 1_000_000_000;
    localparam int SEC_CYCLES = SEC_NS / CLK_PERIOD_NS;
    // Frame length limits in bytes
    localparam logic [10:0] MAX_FRAME = 11'h0600;
    localparam logic [10:0] MIN_FRAME = 11'h0040;
    localparam logic [10:0] LEN_SAT = 11'h07FF;
    // Header byte positions
    localparam logic [10:0] SA_POS = 11'h0006;
    localparam logic [10:0] TYPE_POS = 11'h000C;
    localparam logic [10:0] TAG_POS = 11'h000E;
    // Aging time in seconds
    localparam logic [9:0] AGE_DEFAULT_S = 10'h0028;
    localparam logic [9:0] AGE_MIN_S = 10'h000A;
    localparam logic [9:0] AGE_MAX_S = 10'h0339;
    // Address table size
    localparam int TABLE_DEPTH = 16386;
    // Tag and control frame identifiers
    localparam logic [15:0] TPID = 16'h8100;
    localparam logic [47:0] BPDU_DA = 48'h0180_C200_0000;
    localparam logic [2:0] CLASS_LOW = 3'h0;
    localparam logic [2:0] CLASS_HIGH = 3'h7;
    // Controller states
    typedef enum logic [1:0] {ST_RX, ST_LOOK, ST_TX, ST_SWEEP} state_t;
endpackage

// ### testbench/station_model.sv
// Purpose: End stations feeding and draining the switch core
// Assumes: One byte per accepted cycle on both streams
// Notes: Idle ingress data shows the inverse of the last byte
`timescale 1ns/10ps
module station_model #(
    parameter int NP = 4
) (
    input wire logic core_clk,
    output logic rx_valid,
    input wire logic rx_ready,
    output logic [7:0] rx_data,
    output logic rx_last,
    output logic rx_crc_err,
    output logic [$clog2(NP)-1:0] rx_port,
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic [7:0] tx_data,
    input wire logic tx_last,
    input wire logic [NP-1:0] tx_port_mask,
    input wire logic [2:0] tx_class,
    input wire logic [1:0] tx_queue
);
    int seed = 58546; // Stall pattern seed
    logic [7:0] cur[$]; // Frame being collected
    logic [7:0] got[$]; // Last whole egress frame
    logic [NP-1:0] got_mask;
    logic [2:0] got_class;
    logic [1:0] got_queue;
    int n_frames = 0; // Whole frames seen

    // Quiet lines at time zero
    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
        rx_last = 1'b0;
        rx_crc_err = 1'b0;
        rx_port = '0;
        tx_ready = 1'b0;
    end

    // Offer bytes back to back; each is held until the edge that takes it
    // Ready comes from state only, so its value at negedge is the one seen
    task automatic send(input logic [7:0] b[$], input logic [1:0] p,
                        input logic bad);
        for (int i = 0; i < b.size(); i++) begin
            rx_valid <= 1'b1;
            rx_data <= b[i];
            rx_last <= (i == b.size() - 1);
            rx_crc_err <= bad && (i == b.size() - 1);
            rx_port <= p;
            do @(negedge core_clk); while (rx_ready !== 1'b1);
            @(posedge core_clk);
            #1;
        end
        rx_valid <= 1'b0;
        rx_last <= 1'b0;
        rx_crc_err <= 1'b0;
        rx_data <= ~b[b.size() - 1];
    endtask

    // Random stalls so the core must hold its egress byte
    always @(posedge core_clk) tx_ready <= #1 ($random(seed) % 4 != 0);

    // Collect accepted bytes; both sides are settled at negedge
    always @(negedge core_clk) begin
        if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
            cur.push_back(tx_data);
            got_mask = tx_port_mask;
            got_class = tx_class;
            got_queue = tx_queue;
            if (tx_last === 1'b1) begin
                got = cur;
                cur.delete();
                n_frames++;
            end
        end
    end
endmodule

// ### testbench/learning_frame_switch_core_bench.sv
// Purpose: Self-checking bench for the frame switch core
// Assumes: Four ports, short table and short second for run time
// Notes: Expected masks follow from which stations were learned where
`timescale 1ns/10ps
module learning_frame_switch_core_bench;
    localparam logic [47:0] BC = 48'hFFFF_FFFF_FFFF; // Broadcast
    // Stations picked so that no two of them share a table slot
    localparam logic [47:0] SA = 48'h0200_0000_0001; // Station A
    localparam logic [47:0] SB = 48'h0200_0000_0004; // Station B
    localparam logic [47:0] SC = 48'h0200_0000_0008; // Station C
    localparam logic [47:0] SD = 48'h0200_0000_0003; // Station D
    logic core_clk, rstn, rx_valid, rx_ready, rx_last, rx_crc_err;
    logic [7:0] rx_data, tx_data;
    logic [1:0] rx_port, tx_queue;
    logic [3:0] link_up, tx_port_mask;
    logic clear_table, tx_valid, tx_ready, tx_last;
    logic [9:0] age_time_s;
    logic [2:0] tx_class;
    int n_fail = 0;
    int num_checks = 0;
    int cycles = 0;
    int seed = 58546;
    int p, len, pri;

    // Short table and one-second tick of 20 cycles
    frame_switch_core #(.NUM_PORTS(4), .DEPTH(16), .SEC_CYCLES(20))
        i_frame_switch_core (.core_clk, .rstn, .rx_valid, .rx_ready,
        .rx_data, .rx_last, .rx_crc_err, .rx_port, .link_up, .clear_table,
        .age_time_s, .tx_valid, .tx_ready, .tx_data, .tx_last,
        .tx_port_mask, .tx_class, .tx_queue);

    station_model #(.NP(4)) i_station_model (.core_clk, .rx_valid,
        .rx_ready, .rx_data, .rx_last, .rx_crc_err, .rx_port, .tx_valid,
        .tx_ready, .tx_data, .tx_last, .tx_port_mask, .tx_class,
        .tx_queue);

    task automatic tally_and_finish();
        if (n_fail == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input logic ok, input string what);
        num_checks++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("BAD %0t %s", $time, what);
        end
    endtask

    // Flood set: every live port but the ingress one
    function automatic logic [3:0] fl(input int p);
        return link_up & ~(4'h1 << p);
    endfunction

    // One frame in; then either that exact frame out or nothing at all
    task automatic xfer(input logic [47:0] da, input logic [47:0] sa,
        input int p, input int len, input int pri, input logic bad,
        input logic [3:0] em, input logic [2:0] ec);
        logic [7:0] b[$];
        int n0;
        int k;
        n0 = i_station_model.n_frames;
        for (k = 0; k < 6; k++) b.push_back(da[47-8*k -: 8]);
        for (k = 0; k < 6; k++) b.push_back(sa[47-8*k -: 8]);
        if (pri >= 0) begin
            b.push_back(8'h81);
            b.push_back(8'h00);
            b.push_back({pri[2:0], 5'h00});
        end
        while (b.size() < len) b.push_back(8'($random(seed)));
        i_station_model.send(b, 2'(p), bad);
        // A dropped frame would show within two cycles; allow margin
        k = 0;
        while (i_station_model.n_frames == n0 &&
               k < (em == 4'h0 ? 100 : 4 * len + 200)) begin
            @(posedge core_clk);
            k++;
        end
        #1;
        if (em == 4'h0) begin
            check(i_station_model.n_frames == n0 &&
                  i_station_model.cur.size() == 0, "frame not dropped");
        end else begin
            check(i_station_model.n_frames == n0 + 1 &&
                  i_station_model.got == b, "egress frame wrong");
            check(i_station_model.got_mask === em &&
                  i_station_model.got_class === ec &&
                  i_station_model.got_queue === ec[2:1], "mask or class");
        end
    endtask

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // Hang guard well above the expected run length
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 60000) begin
            n_fail++;
            tally_and_finish();
        end
    end

    initial begin
        rstn = 1'b0;
        link_up = 4'hF;
        clear_table = 1'b0;
        age_time_s = 10'h012C; // Static setup keeps stations
        repeat (8) @(posedge core_clk);
        #1;
        rstn = 1'b1;
        check(rx_ready === 1'b0, "ready during sweep");
        xfer(BC, SA, 1, 64, -1, 0, fl(1), 3'h0);
        xfer(SA, SB, 2, 80, -1, 0, 4'h2, 3'h0);
        xfer(SB, SA, 1, 65, 3, 0, 4'h4, 3'h3);
        xfer(SA, SC, 1, 70, -1, 0, 4'h0, 3'h0);
        for (int i = 0; i < 8; i++) begin
            xfer(BC, SC, 3, 64 + i, i, 0, fl(3), 3'(i));
        end
        xfer(fsw_pkg::BPDU_DA, SC, 0, 64, 2, 0, fl(0), 3'h7);
        xfer(BC, SC, 0, 63, -1, 0, 4'h0, 3'h0);
        xfer(BC, SC, 0, 64, -1, 0, fl(0), 3'h0);
        xfer(BC, SC, 2, 1536, -1, 0, fl(2), 3'h0);
        xfer(BC, SC, 2, 1537, -1, 0, 4'h0, 3'h0);
        xfer(BC, SD, 2, 100, -1, 1, 4'h0, 3'h0);
        xfer(SD, SA, 1, 64, -1, 0, fl(1), 3'h0);
        // Random broadcast traffic with random tags and lengths
        for (int i = 0; i < 12; i++) begin
            p = $random(seed) & 3;
            len = 64 + ($random(seed) & 63);
            pri = ($random(seed) & 1) ? ($random(seed) & 7) : -1;
            // Random aging time, long enough to keep learned stations
            age_time_s = 10'h012C + 10'($random(seed) & 255);
            xfer(BC, SC, p, len, pri, 0, fl(p), 3'(pri < 0 ? 0 : pri));
        end
        // Link loss on port 2 forgets B but keeps A
        xfer(BC, SB, 2, 64, -1, 0, fl(2), 3'h0);
        link_up = 4'hB;
        repeat (40) @(posedge core_clk);
        #1;
        link_up = 4'hF;
        xfer(SB, SA, 1, 64, -1, 0, fl(1), 3'h0);
        xfer(SA, SC, 3, 64, -1, 0, 4'h2, 3'h0);
        // Clear pulse empties everything
        clear_table = 1'b1;
        @(posedge core_clk);
        #1;
        clear_table = 1'b0;
        repeat (40) @(posedge core_clk);
        #1;
        xfer(SA, SC, 3, 64, -1, 0, fl(3), 3'h0);
        // Short aging: fresh entry holds, stale entry is removed
        age_time_s = 10'h000F;
        xfer(BC, SA, 1, 64, -1, 0, fl(1), 3'h0);
        xfer(SA, SC, 3, 64, -1, 0, 4'h2, 3'h0);
        repeat (450) @(posedge core_clk);
        #1;
        xfer(SA, SC, 3, 64, -1, 0, fl(3), 3'h0);
        // Restart in mid-run forgets a learned station
        age_time_s = 10'h012C;
        xfer(BC, SA, 1, 64, -1, 0, fl(1), 3'h0);
        rstn = 1'b0;
        repeat (3) @(posedge core_clk);
        #1;
        rstn = 1'b1;
        xfer(SA, SC, 3, 64, -1, 0, fl(3), 3'h0);
        tally_and_finish();
    end
endmodule
